// ==== verilog/framing_status_and_tx_length_regs.sv ====
`timescale 1ns/1ps
// Operation
// - Collision report bits 7:4 hold full bytes received before first collision.
// - Collision report bits 3:1 hold bit position inside the colliding byte.
// - Collision report bit 0 flags a first collision on a parity bit.
// - Collision report updates only for anticollision-length frames, never longer.
// - Collision, rate and converter registers read zero after reset or restore.
// - Transmit count is 13 bits: high eight at 1Dh, low five at 1Eh[7:3].
// - 1Eh bits 2:0 give split byte bits; zero means all bytes complete.
// - A split last byte sends a bit-oriented frame without parity bits.
// - Both transmit count registers clear at reset and on restore.
// - Detected peer bit rate sits in bits 7:4; low bits read zero.
// - Converter register shows full 8-bit result of the latest conversion.
// - Anticollision on, card idle, split nonzero: wake-up command raises parity error.
module framing_status_and_tx_length_regs (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Framing engine side
   input  wire logic        restore_defaults,
   input  wire logic        frame_start,
   input  wire logic        short_frame,
   input  wire logic        coll_event,
   input  wire logic [3:0]  coll_bytes,
   input  wire logic [2:0]  coll_bits,
   input  wire logic        coll_in_parity,
   input  wire logic        rate_valid,
   input  wire logic [3:0]  rate_code,
   input  wire logic        adc_valid,
   input  wire logic [7:0]  adc_result,
   input  wire logic        card_idle,
   input  wire logic        wupa_cmd,
   output logic      [12:0] tx_byte_count,
   output logic      [2:0]  tx_split_bits,
   output logic             tx_bit_oriented,
   output logic             tx_parity_en,
   output logic             parity_error_pulse,
   output logic             irq
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   localparam int IW = frame_regs_pkg::IRQ_W;
   localparam int NR = frame_regs_pkg::NUM_REGS;

   frame_regs_pkg::bus_state_t state_ff;
   frame_regs_pkg::bus_state_t nxt_state;

   logic [NR-1:0] sel_ff;
   logic [31:0]   hrdata_ff;
   logic          addr_ok;
   logic          wr_stb;
   logic          rd_stb;
   logic [7:0]    ntx_hi_ff;
   logic [7:0]    ntx_lo_ff;
   logic [7:0]    rate_ff;
   logic [7:0]    adc_ff;
   logic [7:0]    ctrl_ff;
   logic [IW-1:0] stat_ff;
   logic [IW-1:0] mask_ff;
   logic [IW-1:0] event_vec;
   logic [7:0]    coll_report;
   logic          coll_captured;
   logic          par_err;
   logic          par_err_ff;
   logic [7:0]    rd_mux;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   // Word index from a byte address; only the low block is mapped
   function automatic logic [NR-1:0] decode(input logic [31:0] a);
      logic [NR-1:0] s;
      s = '0;
      if (a[31:10] == 22'h00_0000) begin
         case (a[9:2])
            frame_regs_pkg::IDX_COLL:     s[frame_regs_pkg::S_COLL]     = 1'b1;
            frame_regs_pkg::IDX_NTX_HI:   s[frame_regs_pkg::S_NTX_HI]   = 1'b1;
            frame_regs_pkg::IDX_NTX_LO:   s[frame_regs_pkg::S_NTX_LO]   = 1'b1;
            frame_regs_pkg::IDX_RATE:     s[frame_regs_pkg::S_RATE]     = 1'b1;
            frame_regs_pkg::IDX_ADC:      s[frame_regs_pkg::S_ADC]      = 1'b1;
            frame_regs_pkg::IDX_CTRL:     s[frame_regs_pkg::S_CTRL]     = 1'b1;
            frame_regs_pkg::IDX_IRQ_STAT: s[frame_regs_pkg::S_IRQ_STAT] = 1'b1;
            frame_regs_pkg::IDX_IRQ_MASK: s[frame_regs_pkg::S_IRQ_MASK] = 1'b1;
            default:                      s = '0;
         endcase
      end
      return s;
   endfunction : decode

   // -----------------------------------------------------------------
   // Bus slave sequencing
   // -----------------------------------------------------------------
   // Only word transfers are expected, so hsize is not decoded
   assign addr_ok = hsel & hready & htrans[1];
   assign wr_stb  = (state_ff == frame_regs_pkg::BUS_WRITE);
   assign rd_stb  = (state_ff == frame_regs_pkg::BUS_RDWAIT);

   // Reads take one wait state so the data comes from a flip-flop
   always_comb begin
      nxt_state = frame_regs_pkg::BUS_IDLE;
      case (state_ff)
         frame_regs_pkg::BUS_RDWAIT: nxt_state = frame_regs_pkg::BUS_RDDONE;
         frame_regs_pkg::BUS_IDLE,
         frame_regs_pkg::BUS_WRITE,
         frame_regs_pkg::BUS_RDDONE: begin
            if (addr_ok && hwrite) begin
               nxt_state = frame_regs_pkg::BUS_WRITE;
            end else if (addr_ok) begin
               nxt_state = frame_regs_pkg::BUS_RDWAIT;
            end
         end
         default: nxt_state = frame_regs_pkg::BUS_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= frame_regs_pkg::BUS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_ff <= '0;
      end else if (addr_ok) begin
         sel_ff <= decode(haddr);
      end else if (!rd_stb) begin
         sel_ff <= '0;
      end
   end

   assign hreadyout = ~rd_stb;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   // Unmapped addresses read zero
   always_comb begin
      rd_mux = 8'h00;
      case (1'b1)
         sel_ff[frame_regs_pkg::S_COLL]:     rd_mux = coll_report;
         sel_ff[frame_regs_pkg::S_NTX_HI]:   rd_mux = ntx_hi_ff;
         sel_ff[frame_regs_pkg::S_NTX_LO]:   rd_mux = ntx_lo_ff;
         sel_ff[frame_regs_pkg::S_RATE]:     rd_mux = rate_ff;
         sel_ff[frame_regs_pkg::S_ADC]:      rd_mux = adc_ff;
         sel_ff[frame_regs_pkg::S_CTRL]:     rd_mux = ctrl_ff;
         sel_ff[frame_regs_pkg::S_IRQ_STAT]: rd_mux = {4'h0, stat_ff};
         sel_ff[frame_regs_pkg::S_IRQ_MASK]: rd_mux = {4'h0, mask_ff};
         default:                            rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_stb) begin
         hrdata_ff <= {24'h00_0000, rd_mux};
      end
   end

   // -----------------------------------------------------------------
   // Collision report
   // -----------------------------------------------------------------
   // Read only: no bus write path exists into this capture
   collision_capture u_coll (
      .hclk             (hclk),
      .hresetn          (hresetn),
      .restore_defaults (restore_defaults),
      .frame_start      (frame_start),
      .short_frame      (short_frame),
      .coll_event       (coll_event),
      .coll_bytes       (coll_bytes),
      .coll_bits        (coll_bits),
      .coll_in_parity   (coll_in_parity),
      .report_ff        (coll_report),
      .captured         (coll_captured)
   );

   // -----------------------------------------------------------------
   // Transmit length registers
   // -----------------------------------------------------------------
   // Restore beats a write landing in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ntx_hi_ff <= frame_regs_pkg::REG_RESET;
      end else if (restore_defaults) begin
         ntx_hi_ff <= frame_regs_pkg::REG_RESET;
      end else if (wr_stb && sel_ff[frame_regs_pkg::S_NTX_HI]) begin
         ntx_hi_ff <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ntx_lo_ff <= frame_regs_pkg::REG_RESET;
      end else if (restore_defaults) begin
         ntx_lo_ff <= frame_regs_pkg::REG_RESET;
      end else if (wr_stb && sel_ff[frame_regs_pkg::S_NTX_LO]) begin
         ntx_lo_ff <= hwdata[7:0];
      end
   end

   // Count is not range checked; the host keeps it legal
   assign tx_byte_count = {ntx_hi_ff, ntx_lo_ff[7:frame_regs_pkg::NTX_LO_LSB]};
   assign tx_split_bits = ntx_lo_ff[frame_regs_pkg::NBTX_W-1:0];
   // Split last byte means a bit-oriented frame with no parity
   assign tx_bit_oriented = (tx_split_bits != 3'h0);
   assign tx_parity_en    = ~tx_bit_oriented;

   // -----------------------------------------------------------------
   // Rate and converter results
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rate_ff <= frame_regs_pkg::REG_RESET;
      end else if (restore_defaults) begin
         rate_ff <= frame_regs_pkg::REG_RESET;
      end else if (rate_valid) begin
         rate_ff <= {rate_code, 4'h0};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         adc_ff <= frame_regs_pkg::REG_RESET;
      end else if (restore_defaults) begin
         adc_ff <= frame_regs_pkg::REG_RESET;
      end else if (adc_valid) begin
         adc_ff <= adc_result;
      end
   end

   // -----------------------------------------------------------------
   // Control and wake-up parity check
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= frame_regs_pkg::REG_RESET;
      end else if (restore_defaults) begin
         ctrl_ff <= frame_regs_pkg::REG_RESET;
      end else if (wr_stb && sel_ff[frame_regs_pkg::S_CTRL]) begin
         ctrl_ff <= {7'h00, hwdata[frame_regs_pkg::CTRL_ANCTL]};
      end
   end

   // Wake-up to an idle card with anticollision on and a pending split count flags a parity error
   assign par_err = wupa_cmd & card_idle & tx_bit_oriented
                  & ctrl_ff[frame_regs_pkg::CTRL_ANCTL];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         par_err_ff <= 1'b0;
      end else begin
         par_err_ff <= par_err;
      end
   end

   assign parity_error_pulse = par_err_ff;

   // -----------------------------------------------------------------
   // Interrupts
   // -----------------------------------------------------------------
   assign event_vec[frame_regs_pkg::IRQ_COLL] = coll_captured;
   assign event_vec[frame_regs_pkg::IRQ_RATE] = rate_valid;
   assign event_vec[frame_regs_pkg::IRQ_ADC]  = adc_valid;
   assign event_vec[frame_regs_pkg::IRQ_PAR]  = par_err;

   // Sticky bits; a new event beats the read that clears it
   for (genvar i = 0; i < IW; i++) begin : g_stat
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            stat_ff[i] <= 1'b0;
         end else if (event_vec[i]) begin
            stat_ff[i] <= 1'b1;
         end else if (restore_defaults ||
                      (rd_stb && sel_ff[frame_regs_pkg::S_IRQ_STAT])) begin
            stat_ff[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_ff <= '0;
      end else if (restore_defaults) begin
         mask_ff <= '0;
      end else if (wr_stb && sel_ff[frame_regs_pkg::S_IRQ_MASK]) begin
         mask_ff <= hwdata[IW-1:0];
      end
   end

   assign irq = |(stat_ff & mask_ff);

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_RESTORE_CLEARS: assert property (
      restore_defaults |=> coll_report == 8'h00 && rate_ff == 8'h00
                           && adc_ff == 8'h00)
      else $error("restore left a status register nonzero");
   AST_TX_RESTORE: assert property (
      restore_defaults |=> tx_byte_count == 13'h0000 && tx_split_bits == 3'h0)
      else $error("restore left a transmit count nonzero");
   AST_NTX_HI_WRITE: assert property (
      wr_stb && sel_ff[frame_regs_pkg::S_NTX_HI] && !restore_defaults
      |=> tx_byte_count[12:5] == $past(hwdata[7:0]))
      else $error("high transmit count not taken");
   AST_NTX_LO_WRITE: assert property (
      wr_stb && sel_ff[frame_regs_pkg::S_NTX_LO] && !restore_defaults
      |=> tx_byte_count[4:0] == $past(hwdata[7:3])
          && tx_split_bits == $past(hwdata[2:0]))
      else $error("low transmit count or split bits not taken");
   AST_SPLIT_NO_PARITY: assert property (
      tx_split_bits != 3'h0 |-> tx_bit_oriented && !tx_parity_en)
      else $error("split byte sent with parity");
   AST_RATE_FIELD: assert property (
      rate_valid && !restore_defaults
      |=> rate_ff[7:4] == $past(rate_code) && rate_ff[3:0] == 4'h0)
      else $error("detected rate field wrong");
   AST_ADC_RESULT: assert property (
      adc_valid && !restore_defaults |=> adc_ff == $past(adc_result))
      else $error("converter result not shown");
   AST_WUPA_PARITY: assert property (
      wupa_cmd && card_idle && ctrl_ff[0] && tx_split_bits != 3'h0
      |=> parity_error_pulse && stat_ff[frame_regs_pkg::IRQ_PAR])
      else $error("wake-up parity error missing");
   AST_RO_WRITE: assert property (
      wr_stb && (sel_ff[frame_regs_pkg::S_RATE] || sel_ff[frame_regs_pkg::S_ADC])
      && !rate_valid && !adc_valid && !restore_defaults
      |=> $stable(rate_ff) && $stable(adc_ff))
      else $error("write changed a read-only register");
   AST_READ_WAIT: assert property (
      rd_stb |-> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   COV_WRITE_THEN_READ: cover property (
      wr_stb && sel_ff[frame_regs_pkg::S_NTX_LO] ##1 rd_stb);
   COV_IRQ_RISE: cover property ($rose(irq));
   COV_WUPA_ERR: cover property (parity_error_pulse);

endmodule : framing_status_and_tx_length_regs

// ==== shared/frame_regs_pkg.sv ====
package frame_regs_pkg;

   // -----------------------------------------------------------------
   // Register indices; byte address is four times the index
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_COLL     = 8'h1c;
   localparam logic [7:0] IDX_NTX_HI   = 8'h1d;
   localparam logic [7:0] IDX_NTX_LO   = 8'h1e;
   localparam logic [7:0] IDX_RATE     = 8'h1f;
   localparam logic [7:0] IDX_ADC      = 8'h20;
   localparam logic [7:0] IDX_CTRL     = 8'h24;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h25;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h26;

   // Select vector positions, one per register
   localparam int S_COLL     = 0;
   localparam int S_NTX_HI   = 1;
   localparam int S_NTX_LO   = 2;
   localparam int S_RATE     = 3;
   localparam int S_ADC      = 4;
   localparam int S_CTRL     = 5;
   localparam int S_IRQ_STAT = 6;
   localparam int S_IRQ_MASK = 7;
   localparam int NUM_REGS   = 8;

   // -----------------------------------------------------------------
   // Field layouts and reset values
   // -----------------------------------------------------------------
   localparam int COLL_BYTE_LSB = 4;
   localparam int COLL_BIT_LSB  = 1;
   localparam int COLL_PAR_BIT  = 0;
   localparam int RATE_LSB      = 4;
   localparam int NTX_LO_LSB    = 3;
   localparam int NTX_W         = 13;
   localparam int NBTX_W        = 3;
   localparam int CTRL_ANCTL    = 0;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Interrupt status / mask bit positions
   localparam int IRQ_COLL = 0;
   localparam int IRQ_RATE = 1;
   localparam int IRQ_ADC  = 2;
   localparam int IRQ_PAR  = 3;
   localparam int IRQ_W    = 4;

   // Bus slave states, one-hot
   typedef enum logic [3:0] {
      BUS_IDLE   = 4'b0001,
      BUS_WRITE  = 4'b0010,
      BUS_RDWAIT = 4'b0100,
      BUS_RDDONE = 4'b1000
   } bus_state_t;

endpackage : frame_regs_pkg

// ==== verilog/collision_capture.sv ====
`timescale 1ns/1ps
module collision_capture (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       restore_defaults,
   input  wire logic       frame_start,
   input  wire logic       short_frame,
   input  wire logic       coll_event,
   input  wire logic [3:0] coll_bytes,
   input  wire logic [2:0] coll_bits,
   input  wire logic       coll_in_parity,
   output logic      [7:0] report_ff,
   output logic            captured
);

   logic seen_ff;
   logic first_coll;

   // A new frame forgets earlier collisions
   assign first_coll = coll_event & (frame_start | ~seen_ff);
   // Longer messages never touch the report
   assign captured   = first_coll & short_frame & ~restore_defaults;

   // -----------------------------------------------------------------
   // First collision of the current frame
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_ff <= 1'b0;
      end else if (coll_event) begin
         seen_ff <= 1'b1;
      end else if (frame_start) begin
         seen_ff <= 1'b0;
      end
   end

   // Report register; restore has priority over a capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         report_ff <= frame_regs_pkg::REG_RESET;
      end else if (restore_defaults) begin
         report_ff <= frame_regs_pkg::REG_RESET;
      end else if (captured) begin
         report_ff <= {coll_bytes, coll_bits, coll_in_parity};
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   AST_COLL_FIELDS: assert property (@(posedge hclk) disable iff (!hresetn)
      captured |=> report_ff == {$past(coll_bytes), $past(coll_bits),
                                 $past(coll_in_parity)})
      else $error("collision report fields wrong");
   AST_COLL_PARITY: assert property (@(posedge hclk) disable iff (!hresetn)
      captured && coll_in_parity |=> report_ff[0])
      else $error("parity collision flag not set");
   AST_COLL_LONG: assert property (@(posedge hclk) disable iff (!hresetn)
      coll_event && !short_frame && !restore_defaults |=> $stable(report_ff))
      else $error("long frame changed collision report");
   COV_COLL_SHORT: cover property (@(posedge hclk) disable iff (!hresetn)
      captured ##1 report_ff != 8'h00);

endmodule : collision_capture

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host microcontroller as an AHB-Lite master
// ----------------------------------------------------------------
module host_model (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   logic        rdy_s;
   logic [31:0] rd_s;

   // Idle bus from time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // Settled copies; inputs only move just after a rising edge
   always @(negedge hclk) begin
      rdy_s = hready;
      rd_s  = hrdata;
   end

   // Bounded wait for hready at a rising edge
   task automatic wait_rdy(output logic ok);
      int n;
      ok = 1'b0;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge hclk);
         ok = rdy_s;
      end
   endtask : wait_rdy

   // One word; counts written never exceed 8191 full bytes
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd,
                       output logic ok);
      logic ok1;
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {22'h00_0000, idx, 2'h0};
      wait_rdy(ok1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      wait_rdy(ok);
      ok = ok & ok1;
      rd = rd_s[7:0];
      hwdata <= ~hwdata; // Released lane must not keep stale data
   endtask : xfer
endmodule : host_model

// ==== verif/framing_status_and_tx_length_regs_test.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the framing status and transmit length registers
// ----------------------------------------------------------------
module framing_status_and_tx_length_regs_test;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_bit_oriented;
   logic tx_parity_en, parity_error_pulse, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, lv;
   logic [2:0]  hsize, tx_split_bits;
   logic [12:0] tx_byte_count;
   logic [5:0]  pls;
   logic [7:0]  dat;
   int          fails, checked;

   host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   // Pulses and data bundles shared by all framing inputs
   framing_status_and_tx_length_regs DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .restore_defaults(pls[5]), .frame_start(pls[4]),
      .short_frame(lv[1]), .coll_event(pls[3]), .coll_bytes(dat[7:4]),
      .coll_bits(dat[3:1]), .coll_in_parity(dat[0]),
      .rate_valid(pls[2]), .rate_code(dat[7:4]), .adc_valid(pls[1]),
      .adc_result(dat), .card_idle(lv[0]), .wupa_cmd(pls[0]),
      .tx_byte_count(tx_byte_count), .tx_split_bits(tx_split_bits),
      .tx_bit_oriented(tx_bit_oriented), .tx_parity_en(tx_parity_en),
      .parity_error_pulse(parity_error_pulse), .irq(irq));

   // Clock at 20 MHz
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic give_verdict;
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
         fails++;
      end
   endtask : chk

   // Bus access; a hung bus ends the run at once
   task automatic acc(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
      logic ok;
      host.xfer(w, idx, wd, rd, ok);
      if (!ok) begin
         $display("mismatch at %0t: bus hung", $time);
         fails++;
         give_verdict();
      end
      #1;
   endtask : acc

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      logic [7:0] d;
      acc(1'b1, idx, wd, d);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] d;
      acc(1'b0, idx, 8'h00, d);
      chk(32'(d), 32'(e));
   endtask : rd

   // Bits: restore, frame, collision, rate, adc, wake-up
   task automatic pulse(input logic [5:0] p, input logic [7:0] d,
                        input logic [1:0] l);
      @(posedge hclk);
      pls <= p;
      dat <= d;
      lv  <= l;
      @(posedge hclk);
      pls <= 6'h00;
      #1;
   endtask : pulse

   task automatic t_reset;
      rd(frame_regs_pkg::IDX_COLL, 8'h00);
      rd(frame_regs_pkg::IDX_NTX_HI, 8'h00);
      rd(frame_regs_pkg::IDX_NTX_LO, 8'h00);
      rd(frame_regs_pkg::IDX_RATE, 8'h00);
      rd(frame_regs_pkg::IDX_ADC, 8'h00);
      chk(32'(tx_parity_en), 32'h0000_0001);
      chk(32'(hresp), 32'h0000_0000);
   endtask : t_reset

   // Largest count with a split byte, then whole bytes only
   task automatic t_tx;
      wr(frame_regs_pkg::IDX_NTX_HI, 8'hff);
      wr(frame_regs_pkg::IDX_NTX_LO, 8'hfd);
      chk(32'(tx_byte_count), 32'h0000_1fff);
      chk(32'(tx_split_bits), 32'h0000_0005);
      chk(32'({tx_bit_oriented, tx_parity_en}), 32'h0000_0002);
      rd(frame_regs_pkg::IDX_NTX_LO, 8'hfd);
      wr(frame_regs_pkg::IDX_NTX_HI, 8'h80);
      wr(frame_regs_pkg::IDX_NTX_LO, 8'h08);
      chk(32'(tx_byte_count), 32'h0000_1001);
      chk(32'({tx_bit_oriented, tx_parity_en}), 32'h0000_0001);
   endtask : t_tx

   // First collision only, short frames only, host writes dropped
   task automatic t_coll;
      pulse(6'h18, 8'hab, 2'h2);
      rd(frame_regs_pkg::IDX_COLL, 8'hab);
      pulse(6'h08, 8'h34, 2'h2);
      rd(frame_regs_pkg::IDX_COLL, 8'hab);
      pulse(6'h10, 8'h00, 2'h0);
      pulse(6'h08, 8'h56, 2'h0);
      rd(frame_regs_pkg::IDX_COLL, 8'hab);
      wr(frame_regs_pkg::IDX_COLL, 8'h11);
      rd(frame_regs_pkg::IDX_COLL, 8'hab);
      pulse(6'h18, 8'h0e, 2'h2);
      rd(frame_regs_pkg::IDX_COLL, 8'h0e);
   endtask : t_coll

   task automatic t_rate_adc;
      pulse(6'h06, 8'h9c, 2'h0);
      wr(frame_regs_pkg::IDX_RATE, 8'hff);
      wr(frame_regs_pkg::IDX_ADC, 8'hff);
      rd(frame_regs_pkg::IDX_RATE, 8'h90);
      rd(frame_regs_pkg::IDX_ADC, 8'h9c);
   endtask : t_rate_adc

   // Sticky status, masking, read clear and an unmapped read
   task automatic t_irq;
      rd(frame_regs_pkg::IDX_IRQ_STAT, 8'h07);
      pulse(6'h02, 8'h55, 2'h0);
      chk(32'(irq), 32'h0000_0000);
      wr(frame_regs_pkg::IDX_IRQ_MASK, 8'h04);
      chk(32'(irq), 32'h0000_0001);
      rd(frame_regs_pkg::IDX_IRQ_STAT, 8'h04);
      chk(32'(irq), 32'h0000_0000);
      rd(8'h30, 8'h00);
   endtask : t_irq

   // Wake-up parity error needs enable, idle card and a split byte
   task automatic t_wupa;
      wr(frame_regs_pkg::IDX_CTRL, 8'h01);
      wr(frame_regs_pkg::IDX_NTX_LO, 8'h03);
      pulse(6'h01, 8'h00, 2'h1);
      chk(32'(parity_error_pulse), 32'h0000_0001);
      rd(frame_regs_pkg::IDX_IRQ_STAT, 8'h08);
      pulse(6'h01, 8'h00, 2'h0);
      chk(32'(parity_error_pulse), 32'h0000_0000);
      wr(frame_regs_pkg::IDX_NTX_LO, 8'h00);
      pulse(6'h01, 8'h00, 2'h1);
      chk(32'(parity_error_pulse), 32'h0000_0000);
      wr(frame_regs_pkg::IDX_NTX_LO, 8'h03);
      wr(frame_regs_pkg::IDX_CTRL, 8'h00);
      pulse(6'h01, 8'h00, 2'h1);
      chk(32'(parity_error_pulse), 32'h0000_0000);
   endtask : t_wupa

   task automatic t_restore;
      wr(frame_regs_pkg::IDX_NTX_HI, 8'h5a);
      wr(frame_regs_pkg::IDX_NTX_LO, 8'h5b);
      pulse(6'h20, 8'h00, 2'h0);
      chk(32'(tx_byte_count), 32'h0000_0000);
      t_reset();
   endtask : t_restore

   // Reset for 16 cycles, then every scenario in turn
   initial begin
      fails   = 0;
      checked = 0;
      pls     = 6'h00;
      dat     = 8'h00;
      lv      = 2'h0;
      hresetn = 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_tx();
      t_coll();
      t_rate_adc();
      t_irq();
      t_wupa();
      t_restore();
      give_verdict();
   end
endmodule : framing_status_and_tx_length_regs_test
